// ---- src/ccr_clock_ctrl.v ----
/*
 * Clock path and alignment-reference receiver control registers.
 * Holds four byte registers behind a simple register port, drives the
 * clock gating and receiver controls, the hysteresis code, a
 * divide-by-two sampling enable, a VCO band recalibration pulse and
 * an edge-qualified alignment pulse.
 * Assumes the register port is synchronous to clk_i and the alignment
 * reference input is asynchronous to it.
 */
// How it works
// - cal_ref_clock_gate at 0 lets the clock reach the serializer PLL and calibration logic, at 1 stops it; reset 1.
// - clock_receiver_powerdown at 0 enables the clock input buffer, at 1 powers it down; reset 1.
// - rf_chain_align_enable set lets alignment-reference timing act on the RF clock chain; reset 1.
// - rf_divider_enable at 1 halves the input clock for sampling, at 0 the divider is off; reset 0.
// - align_ref_receiver_powerdown resets to 1 and must be cleared for deterministic-latency use.
// - hysteresis_on at 1 enables the programmable hysteresis, at 0 disables it; reset 0.
// - align_edge_select at 0 aligns on the falling edge, at 1 on the rising edge; reset 0.
// - setting vco_recalibrate restarts VCO band calibration only, nothing else; reset 0.
`timescale 1ns/1ps
`include "ccr_map.vh"
module ccr_clock_ctrl #(
    parameter ADDR_W = `CCR_ADDR_W
) (
    input wire clk_i,
    input wire rst_i,
    input wire [ADDR_W-1:0] reg_addr_i,
    input wire [7:0] reg_wdata_i,
    input wire reg_wr_i,
    input wire reg_rd_i,
    output reg [7:0] reg_rdata_o,
    output reg reg_rvalid_o,
    input wire align_ref_i,
    output wire cal_clk_en_o,
    output wire clock_receiver_en_o,
    output wire duty_ctrl_en_o,
    output wire rf_divider_enable_o,
    output wire samp_en_o,
    output wire align_ref_receiver_en_o,
    output wire hysteresis_on_o,
    output wire align_edge_select_o,
    output wire [9:0] hysteresis_code_o,
    output wire [9:0] hysteresis_eff_code_o,
    output reg vco_recal_start_o,
    output reg align_pulse_o
);
    reg [7:0] clock_config_lower;
    reg [7:0] alignment_reference_receiver_control;
    reg [7:0] alignment_reference_hysteresis_low;
    reg [7:0] pll_control;
    reg [7:0] next_rdata;
    reg ref_meta;
    reg ref_sync;
    reg ref_prev;
    wire hit_ccl;
    wire hit_src;
    wire hit_shl;
    wire hit_plc;
    wire rise;
    wire fall;
    wire edge_hit;

    assign hit_ccl = (reg_addr_i == `CCR_OFF_CLOCK_CONFIG_LOWER);
    assign hit_src = (reg_addr_i == `CCR_OFF_ALIGNMENT_REFERENCE_RECEIVER_CONTROL);
    assign hit_shl = (reg_addr_i == `CCR_OFF_ALIGNMENT_REFERENCE_HYSTERESIS_LOW);
    assign hit_plc = (reg_addr_i == `CCR_OFF_PLL_CONTROL);

    // writes; masks keep reserved positions at zero
    always @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            clock_config_lower <= `CCR_CLOCK_CONFIG_LOWER_RST;
            alignment_reference_receiver_control <= `CCR_ALIGNMENT_REFERENCE_RECEIVER_CONTROL_RST;
            alignment_reference_hysteresis_low <= `CCR_ALIGNMENT_REFERENCE_HYSTERESIS_LOW_RST;
            pll_control <= `CCR_PLL_CONTROL_RST;
        end else if (reg_wr_i) begin
            if (hit_ccl) begin
                clock_config_lower <= reg_wdata_i & `CCR_CLOCK_CONFIG_LOWER_MASK;
            end
            if (hit_src) begin
                alignment_reference_receiver_control <= reg_wdata_i & `CCR_ALIGNMENT_REFERENCE_RECEIVER_CONTROL_MASK;
            end
            if (hit_shl) begin
                alignment_reference_hysteresis_low <= reg_wdata_i & `CCR_ALIGNMENT_REFERENCE_HYSTERESIS_LOW_MASK;
            end
            if (hit_plc) begin
                pll_control <= reg_wdata_i & `CCR_PLL_CONTROL_MASK;
            end
        end
    end

    // read mux; unmapped offsets return zero
    always @* begin
        next_rdata = 8'h00;
        if (hit_ccl) begin
            next_rdata = clock_config_lower;
        end else if (hit_src) begin
            next_rdata = alignment_reference_receiver_control;
        end else if (hit_shl) begin
            next_rdata = alignment_reference_hysteresis_low;
        end else if (hit_plc) begin
            next_rdata = pll_control;
        end
    end

    always @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            reg_rdata_o <= 8'h00;
            reg_rvalid_o <= 1'b0;
        end else begin
            reg_rvalid_o <= reg_rd_i;
            if (reg_rd_i) begin
                reg_rdata_o <= next_rdata;
            end
        end
    end

    assign cal_clk_en_o = ~clock_config_lower[`CCR_CAL_REF_CLOCK_GATE_BIT];
    assign clock_receiver_en_o = ~clock_config_lower[`CCR_CLOCK_RECEIVER_POWERDOWN_BIT];
    // stored as written; software is expected to leave it at 1
    assign duty_ctrl_en_o = clock_config_lower[`CCR_DUTY_CTRL_ENABLE_BIT];
    assign rf_divider_enable_o = clock_config_lower[`CCR_RF_DIVIDER_ENABLE_BIT];
    assign align_ref_receiver_en_o =
        ~alignment_reference_receiver_control[`CCR_ALIGN_REF_RECEIVER_POWERDOWN_BIT];
    assign hysteresis_on_o = alignment_reference_receiver_control[`CCR_HYSTERESIS_ON_BIT];
    assign align_edge_select_o = alignment_reference_receiver_control[`CCR_ALIGN_EDGE_SELECT_BIT];
    assign hysteresis_code_o = {alignment_reference_receiver_control[`CCR_HYSTERESIS_CODE_HIGH_MSB:
        `CCR_HYSTERESIS_CODE_HIGH_LSB], alignment_reference_hysteresis_low};
    // code has no effect while hysteresis is off
    assign hysteresis_eff_code_o = hysteresis_on_o ? hysteresis_code_o : 10'h000;

    ccr_div2 u_div2 (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .div_en_i(rf_divider_enable_o),
        .samp_en_o(samp_en_o)
    );

    // band recalibration only: one pulse when the bit is written from 0 to 1
    always @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            vco_recal_start_o <= 1'b0;
        end else begin
            vco_recal_start_o <= reg_wr_i & hit_plc & reg_wdata_i[`CCR_VCO_RECALIBRATE_BIT]
                & ~pll_control[`CCR_VCO_RECALIBRATE_BIT];
        end
    end

    // alignment reference is asynchronous: two flops before any logic
    always @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            ref_meta <= 1'b0;
            ref_sync <= 1'b0;
            ref_prev <= 1'b0;
        end else begin
            ref_meta <= align_ref_i;
            ref_sync <= ref_meta;
            ref_prev <= ref_sync;
        end
    end

    assign rise = ref_sync & ~ref_prev;
    assign fall = ~ref_sync & ref_prev;
    assign edge_hit = align_edge_select_o ? rise : fall;

    // powered-down receiver or disabled chain timing gives no alignment
    always @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            align_pulse_o <= 1'b0;
        end else begin
            align_pulse_o <= edge_hit & align_ref_receiver_en_o
                & clock_config_lower[`CCR_RF_CHAIN_ALIGN_ENABLE_BIT];
        end
    end
endmodule

// ---- src/ccr_map.vh ----
/*
 * Register offsets, field positions and reset values of the clock and
 * alignment-reference control registers.
 * Assumes a byte-wide register port with a 12-bit address.
 */
`ifndef CCR_MAP_VH
`define CCR_MAP_VH

`define CCR_ADDR_W 12
`define CCR_OFF_CLOCK_CONFIG_LOWER 12'h080
`define CCR_OFF_ALIGNMENT_REFERENCE_RECEIVER_CONTROL 12'h081
`define CCR_OFF_ALIGNMENT_REFERENCE_HYSTERESIS_LOW 12'h082
`define CCR_OFF_PLL_CONTROL 12'h083

// clock_config_lower fields
`define CCR_CAL_REF_CLOCK_GATE_BIT 4
`define CCR_CLOCK_RECEIVER_POWERDOWN_BIT 3
`define CCR_DUTY_CTRL_ENABLE_BIT 2
`define CCR_RF_CHAIN_ALIGN_ENABLE_BIT 1
`define CCR_RF_DIVIDER_ENABLE_BIT 0
`define CCR_CLOCK_CONFIG_LOWER_MASK 8'h1f
`define CCR_CLOCK_CONFIG_LOWER_RST 8'h1e

// alignment_reference_receiver_control fields
`define CCR_ALIGN_REF_RECEIVER_POWERDOWN_BIT 4
`define CCR_HYSTERESIS_ON_BIT 3
`define CCR_ALIGN_EDGE_SELECT_BIT 2
`define CCR_HYSTERESIS_CODE_HIGH_MSB 1
`define CCR_HYSTERESIS_CODE_HIGH_LSB 0
`define CCR_ALIGNMENT_REFERENCE_RECEIVER_CONTROL_MASK 8'h1f
`define CCR_ALIGNMENT_REFERENCE_RECEIVER_CONTROL_RST 8'h10

// alignment_reference_hysteresis_low
`define CCR_ALIGNMENT_REFERENCE_HYSTERESIS_LOW_MASK 8'hff
`define CCR_ALIGNMENT_REFERENCE_HYSTERESIS_LOW_RST 8'h00

// pll_control fields
`define CCR_VCO_RECALIBRATE_BIT 7
`define CCR_PLL_CONTROL_MASK 8'h80
`define CCR_PLL_CONTROL_RST 8'h00

// hysteresis step per code bit
`define CCR_HYST_STEP_MV 10

`endif

// ---- src/ccr_div2.v ----
/*
 * Divide-by-two sampling enable for the RF clock path.
 * Assumes one clock; the enable is a level from the register file.
 */
`timescale 1ns/1ps
module ccr_div2 (
    input wire clk_i,
    input wire rst_i,
    input wire div_en_i,
    output wire samp_en_o
);
    reg phase;

    // divider off: every cycle is a sample; on: every second cycle
    always @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            phase <= 1'b0;
        end else if (div_en_i) begin
            phase <= ~phase;
        end else begin
            phase <= 1'b0;
        end
    end

    assign samp_en_o = div_en_i ? phase : 1'b1;
endmodule

// ---- tb/ccr_checker.sv ----
/* Port assertions for the clock control registers.
   Bound to ccr_clock_ctrl with its 12-bit address. */
`timescale 1ns/1ps
module ccr_checker (
    input wire clk_i,
    input wire rst_i,
    input wire [11:0] reg_addr_i,
    input wire [7:0] reg_wdata_i,
    input wire reg_wr_i,
    input wire reg_rd_i,
    input wire [7:0] reg_rdata_o,
    input wire reg_rvalid_o,
    input wire cal_clk_en_o,
    input wire samp_en_o,
    input wire rf_divider_enable_o,
    input wire align_ref_receiver_en_o,
    input wire hysteresis_on_o,
    input wire [9:0] hysteresis_code_o,
    input wire [9:0] hysteresis_eff_code_o,
    input wire vco_recal_start_o,
    input wire align_pulse_o
);
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);
    wire w0 = reg_wr_i && reg_addr_i == 12'h080;
    wire w1 = reg_wr_i && reg_addr_i == 12'h081;
    wire w2 = reg_wr_i && reg_addr_i == 12'h082;
    wire w3 = reg_wr_i && reg_addr_i == 12'h083 && reg_wdata_i[7];
    property p_gate; w0 |=> cal_clk_en_o != $past(reg_wdata_i[4]); endproperty
    a_gate: assert property (p_gate) else $error("gate bit wrong");
    property p_half; rf_divider_enable_o && $past(rf_divider_enable_o)
        |-> samp_en_o != $past(samp_en_o); endproperty
    a_half: assert property (p_half) else $error("divider not toggling");
    property p_full; !rf_divider_enable_o |-> samp_en_o; endproperty
    a_full: assert property (p_full) else $error("sampling gated");
    property p_arx; w1 |=> align_ref_receiver_en_o != $past(reg_wdata_i[4]); endproperty
    a_arx: assert property (p_arx) else $error("receiver enable wrong");
    property p_eff; hysteresis_eff_code_o == (hysteresis_on_o ? hysteresis_code_o : 10'h000);
    endproperty
    a_eff: assert property (p_eff) else $error("effective code wrong");
    property p_code; w2 |=> hysteresis_code_o[7:0] == $past(reg_wdata_i); endproperty
    a_code: assert property (p_code) else $error("code low wrong");
    property p_recal; vco_recal_start_o |-> $past(w3) ##1 !vco_recal_start_o; endproperty
    a_recal: assert property (p_recal) else $error("recal pulse wrong");
    property p_unmap; reg_rd_i && reg_addr_i == 12'h084 |=> reg_rvalid_o && !reg_rdata_o;
    endproperty
    a_unmap: assert property (p_unmap) else $error("unmapped read wrong");
    c_recal: cover property (vco_recal_start_o);
    c_align: cover property (align_pulse_o);
    c_half: cover property (w0 ##1 !samp_en_o);
endmodule

// ---- tb/ccr_align_src.sv ----
/* Alignment reference source in place of the clock generator.
   Runs on the core clock; the level stands still while run_i is low. */
`timescale 1ns/1ps
module ccr_align_src #(
    parameter HALF = 4
) (
    input wire clk_i,
    input wire run_i,
    output reg ref_o
);
    integer cnt = 0;
    initial ref_o = 1'b0;
    // levels of HALF cycles keep above the two-cycle synchroniser minimum
    always @(negedge clk_i) begin
        if (run_i) begin
            cnt <= (cnt >= HALF - 1) ? 0 : cnt + 1;
            if (cnt >= HALF - 1) ref_o <= ~ref_o;
        end
    end
endmodule

// ---- tb/ccr_tb_top.sv ----
/* Self-checking bench for ccr_clock_ctrl against a register model.
   Needs the checker and the alignment source compiled first. */
`timescale 1ns/1ps
module clock_alignment_reference_pll_control_regs_tb_top;
    localparam [39:0] MSK = 40'h0080ff1f1f;
    reg clk_i = 1'b0;
    reg rst_i = 1'b1;
    reg [11:0] reg_addr_i = 12'h000;
    reg [7:0] reg_wdata_i = 8'h00;
    reg reg_wr_i = 1'b0;
    reg reg_rd_i = 1'b0;
    reg run = 1'b0;
    reg pv;
    reg [39:0] mr = 40'h000000101e;
    wire align_ref_i, reg_rvalid_o, cal_clk_en_o, clock_receiver_en_o, duty_ctrl_en_o;
    wire rf_divider_enable_o, samp_en_o, align_ref_receiver_en_o, hysteresis_on_o;
    wire align_edge_select_o, vco_recal_start_o, align_pulse_o;
    wire [7:0] reg_rdata_o;
    wire [9:0] hysteresis_code_o, hysteresis_eff_code_o;
    wire [6:0] lv = {cal_clk_en_o, clock_receiver_en_o, duty_ctrl_en_o, rf_divider_enable_o,
        align_ref_receiver_en_o, hysteresis_on_o, align_edge_select_o};
    integer seed = 32'h36344bea;
    integer bad_count = 0;
    integer checks_done = 0;
    integer i, e, n, got;
    always #10 clk_i = ~clk_i;
    ccr_align_src u_ccr_align_src (.clk_i(clk_i), .run_i(run), .ref_o(align_ref_i));
    ccr_clock_ctrl u_ccr_clock_ctrl (.*);
    task chk(input [9:0] g, input [9:0] x);
        begin
            checks_done = checks_done + 1;
            if (g !== x) begin
                bad_count = bad_count + 1;
                $display("wrong value at %0t: got %h expected %h", $time, g, x);
            end
        end
    endtask
    task wr_reg(input [2:0] k, input [7:0] d);
        begin
            reg_addr_i = 12'h080 + k;
            reg_wdata_i = d;
            reg_wr_i = 1'b1;
            @(negedge clk_i);
            reg_wr_i = 1'b0;
            chk(vco_recal_start_o, k == 3 && d[7] && !mr[31]);
            mr[k*8 +: 8] = d & MSK[k*8 +: 8];
            // one idle cycle so a following call never re-raises the strobe in this step
            @(negedge clk_i);
        end
    endtask
    task rd_reg(input [2:0] k);
        begin
            reg_addr_i = 12'h080 + k;
            reg_rd_i = 1'b1;
            @(negedge clk_i);
            reg_rd_i = 1'b0;
            chk({reg_rvalid_o, reg_rdata_o}, {1'b1, mr[k*8 +: 8]});
            @(negedge clk_i);
        end
    endtask
    task ports_chk;
        begin
            chk(lv, {~mr[4], ~mr[3], mr[2], mr[0], ~mr[12], mr[11], mr[10]});
            chk(hysteresis_code_o, {mr[9:8], mr[23:16]});
            chk(hysteresis_eff_code_o, mr[11] ? {mr[9:8], mr[23:16]} : 10'h000);
        end
    endtask
    task stop_test;
        begin
            $display("checks %0d mismatches %0d", checks_done, bad_count);
            if (bad_count == 0 && checks_done > 0)
                $display("[ PASS ]");
            else
                $display("[ FAIL ]");
            $finish;
        end
    endtask
    initial begin
        #100000;
        bad_count = bad_count + 1;
        stop_test;
    end
    initial begin
        repeat (6) @(negedge clk_i);
        rst_i = 1'b0;
        for (i = 0; i < 5; i = i + 1) rd_reg(i);
        ports_chk;
        for (i = 0; i < 40; i = i + 1) begin
            e = $random(seed);
            n = {$random(seed)} % 5;
            // duty control always written as 1
            wr_reg(n, n == 0 ? e[7:0] | 8'h04 : e[7:0]);
            ports_chk;
            rd_reg(n);
        end
        wr_reg(0, 8'h06);
        wr_reg(0, 8'h07);
        // idle cycle in the write task: divider already in its second phase
        chk(samp_en_o, 1);
        @(negedge clk_i);
        chk(samp_en_o, 0);
        // recalibration only after lock and after a PLL change: re-arm, then set
        wr_reg(3, 8'h00);
        wr_reg(3, 8'h80);
        $display("register test done");
        for (e = 0; e < 3; e = e + 1) begin
            wr_reg(0, e < 2 ? 8'h06 : 8'h04);
            wr_reg(1, e == 1 ? 8'h04 : 8'h00);
            n = 0;
            got = 0;
            pv = align_ref_i;
            run = 1'b1;
            for (i = 0; i < 90; i = i + 1) begin
                @(negedge clk_i);
                if (i == 80) run = 1'b0;
                if (e < 2 && align_ref_i !== pv && align_ref_i === e[0]) n = n + 1;
                pv = align_ref_i;
                got = got + align_pulse_o;
            end
            chk(got, n);
        end
        $display("alignment test done");
        stop_test;
    end
endmodule
bind ccr_clock_ctrl ccr_checker u_ccr_checker (.*);
